// [shared/spi_port_consts.svh]
// Constants for the byte-wide serial port
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH
`define BYTE_BITS      8
`define BIT_CNT_LAST   3'h7
`define EDGE_CNT_LAST  4'hF
`define HALF_DIV_W     6
`define HALF_RATE0     6'h01
`define HALF_RATE1     6'h03
`define HALF_RATE2     6'h07
`define HALF_RATE3     6'h0F
`define HALF_RATE4     6'h1F
`define HALF_RATE5     6'h3F
`define RATE_IDX0      3'h0
`define RATE_IDX1      3'h1
`define RATE_IDX2      3'h2
`define RATE_IDX3      3'h3
`define RATE_IDX4      3'h4
`define RESET_BYTE     8'h00
`endif

// [shared/spi_port_pkg.sv]
// Types for the byte-wide serial port
package spi_port_pkg;
  typedef struct packed {
    logic       interrupt_enable;
    logic [2:0] clock_rate_select;
    logic       polarity;
    logic       phase;
    logic       select_by_software;
    logic       software_select_level;
  } cfg_s;
  typedef struct packed {
    logic transfer_done_flag;
    logic overrun_flag;
    logic mode_fault_flag;
    logic write_collision_flag;
  } flags_s;
  typedef enum logic {M_IDLE, M_XFER} mstate_e;
endpackage : spi_port_pkg

// [rtl/spi_master_slave_port.sv]
// Byte-wide serial port, master or slave, with status flags
`include "spi_port_consts.svh"
`timescale 1ns/1ns
module spi_master_slave_port (
  // Clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst_n,
  // Configuration and control
  input  wire spi_port_pkg::cfg_s  i_cfg,
  input  wire logic                i_cpu_interrupt_mask,
  input  wire logic                i_ctl_wr,
  input  wire logic                i_ctl_port_enable,
  input  wire logic                i_ctl_master_select,
  input  wire logic                i_status_rd,
  input  wire logic                i_data_wr,
  input  wire logic [7:0]          i_data_wdata,
  input  wire logic                i_data_rd,
  // Status and data
  output logic                     o_port_enable,
  output logic                     o_master_select,
  output spi_port_pkg::flags_s     o_flags,
  output logic [7:0]               o_rx_data,
  output logic                     o_irq,
  // Serial pins
  input  wire logic                i_sck,
  output logic                     o_sck,
  output logic                     o_sck_oe,
  input  wire logic                i_mosi,
  output logic                     o_mosi,
  output logic                     o_mosi_oe,
  input  wire logic                i_miso,
  output logic                     o_miso,
  output logic                     o_miso_oe,
  input  wire logic                i_ss_n
);
  import spi_port_pkg::*;
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [3:0]              sync1_r, sync2_r, edge_r;
  logic                    sck_last_r, en_r, mst_r, sck_r;
  logic                    done_r, ovr_r, mode_fault_flag_r, write_collision_flag_r;
  logic                    done_arm_r, mode_fault_flag_arm_r, write_collision_flag_arm_r;
  logic [7:0]              shift_r, rx_r;
  mstate_e                 mstate_r;
  logic [`HALF_DIV_W-1:0]  div_r;
  logic [2:0]              bit_r;
  logic                    ss_int, master_en, slave_en, slave_busy, busy;
  logic                    din, m_toggle, m_capture, s_edge, s_capture;
  logic                    capture, byte_end, fault, wr_ignored, wr_load;
  logic                    wr_collide, data_acc, done_clr;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [`HALF_DIV_W-1:0] half_period(
    input logic [2:0] rate
  );
    unique case (rate)
      `RATE_IDX0: half_period = `HALF_RATE0;
      `RATE_IDX1: half_period = `HALF_RATE1;
      `RATE_IDX2: half_period = `HALF_RATE2;
      `RATE_IDX3: half_period = `HALF_RATE3;
      `RATE_IDX4: half_period = `HALF_RATE4;
      default:    half_period = `HALF_RATE5;
    endcase
  endfunction : half_period
  // Capture edge: leading when phase 0, trailing when phase 1
  function automatic logic is_capture(
    input logic new_lvl,
    input logic pol,
    input logic pha
  );
    is_capture = (new_lvl != pol) ^ pha;
  endfunction : is_capture
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      sync1_r    <= 4'hF;
      sync2_r    <= 4'hF;
      sck_last_r <= 1'h1;
    end
    else
    begin
      sync1_r    <= {i_ss_n, i_miso, i_mosi, i_sck};
      sync2_r    <= sync1_r;
      sck_last_r <= sync2_r[0];
    end
  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  assign ss_int     = i_cfg.select_by_software ?
                      i_cfg.software_select_level : sync2_r[3];
  assign master_en  = en_r && mst_r;
  assign slave_en   = en_r && !mst_r && !ss_int;
  assign fault      = master_en && !ss_int;
  assign slave_busy = slave_en && (!i_cfg.phase || bit_r != 3'h0);
  assign busy       = (mstate_r == M_XFER) || slave_busy;
  assign din        = mst_r ? sync2_r[2] : sync2_r[1];
  assign m_toggle   = (mstate_r == M_XFER) &&
                      (div_r == half_period(i_cfg.clock_rate_select));
  assign m_capture  = m_toggle &&
                      is_capture(!sck_r, i_cfg.polarity, i_cfg.phase);
  assign s_edge     = slave_en && (sync2_r[0] != sck_last_r);
  assign s_capture  = s_edge &&
                      is_capture(sync2_r[0], i_cfg.polarity,
                                 i_cfg.phase);
  assign capture    = m_capture || s_capture;
  assign byte_end   = (m_toggle && edge_r == `EDGE_CNT_LAST) ||
                      (s_capture && bit_r == `BIT_CNT_LAST);
  assign wr_ignored = done_r && !done_arm_r;
  assign wr_collide = i_data_wr && !wr_ignored && busy;
  assign wr_load    = i_data_wr && !wr_ignored && !busy;
  assign data_acc   = i_data_rd || i_data_wr;
  assign done_clr   = done_arm_r &&
                      (i_data_rd || (!mst_r && i_data_wr));
  // ------------------------------------------------------------
  // Control bits
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      en_r  <= 1'h0;
      mst_r <= 1'h0;
    end
    else if (fault)
    begin
      en_r  <= 1'h0;
      mst_r <= 1'h0;
    end
    else if (i_ctl_wr)
    begin
      if (mode_fault_flag_r && !mode_fault_flag_arm_r)
      begin
        en_r  <= en_r && i_ctl_port_enable;
        mst_r <= mst_r && i_ctl_master_select;
      end
      else
      begin
        en_r  <= i_ctl_port_enable;
        mst_r <= i_ctl_master_select;
      end
    end
  // ------------------------------------------------------------
  // Master clock generator
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      mstate_r <= M_IDLE;
      div_r    <= '0;
      edge_r   <= 4'h0;
      sck_r    <= 1'h0;
    end
    else if (!master_en)
    begin
      mstate_r <= M_IDLE;
      div_r    <= '0;
      edge_r   <= 4'h0;
      sck_r    <= i_cfg.polarity;
    end
    else
    begin
      unique case (mstate_r)
        M_IDLE:
        begin
          sck_r <= i_cfg.polarity;
          if (wr_load)
          begin
            mstate_r <= M_XFER;
            div_r    <= '0;
            edge_r   <= 4'h0;
          end
        end
        M_XFER:
        begin
          if (m_toggle)
          begin
            div_r  <= '0;
            sck_r  <= !sck_r;
            edge_r <= edge_r + 4'h1;
            if (edge_r == `EDGE_CNT_LAST)
              mstate_r <= M_IDLE;
          end
          else
            div_r <= div_r + `HALF_DIV_W'(1);
        end
      endcase
    end
  // ------------------------------------------------------------
  // Shift register, slave bit counter and receive buffer
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
      shift_r <= `RESET_BYTE;
    else if (wr_load)
      shift_r <= i_data_wdata;
    else if (capture)
      shift_r <= {shift_r[6:0], din};
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
      bit_r <= 3'h0;
    else if (!slave_en)
      bit_r <= 3'h0;
    else if (s_capture)
      bit_r <= bit_r + 3'h1;
  // Master phase 0 ends on a launch edge, so no bit is added then
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
      rx_r <= `RESET_BYTE;
    else if (byte_end && (!done_r || done_clr))
      rx_r <= capture ? {shift_r[6:0], din} : shift_r;
  // ------------------------------------------------------------
  // Status flags; a new event wins over a clear
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      done_r     <= 1'h0;
      done_arm_r <= 1'h0;
    end
    else if (byte_end)
    begin
      done_r     <= 1'h1;
      done_arm_r <= 1'h0;
    end
    else if (done_clr)
    begin
      done_r     <= 1'h0;
      done_arm_r <= 1'h0;
    end
    else if (i_status_rd && done_r)
      done_arm_r <= 1'h1;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
      ovr_r <= 1'h0;
    else if (byte_end && done_r && !done_clr)
      ovr_r <= 1'h1;
    else if (i_status_rd)
      ovr_r <= 1'h0;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      mode_fault_flag_r     <= 1'h0;
      mode_fault_flag_arm_r <= 1'h0;
    end
    else if (fault)
    begin
      mode_fault_flag_r     <= 1'h1;
      mode_fault_flag_arm_r <= 1'h0;
    end
    else if (i_ctl_wr && mode_fault_flag_arm_r)
    begin
      mode_fault_flag_r     <= 1'h0;
      mode_fault_flag_arm_r <= 1'h0;
    end
    else if (i_status_rd && mode_fault_flag_r)
      mode_fault_flag_arm_r <= 1'h1;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      write_collision_flag_r     <= 1'h0;
      write_collision_flag_arm_r <= 1'h0;
    end
    else if (wr_collide)
    begin
      write_collision_flag_r     <= 1'h1;
      write_collision_flag_arm_r <= 1'h0;
    end
    else if (data_acc && write_collision_flag_arm_r)
    begin
      write_collision_flag_r     <= 1'h0;
      write_collision_flag_arm_r <= 1'h0;
    end
    else if (i_status_rd && write_collision_flag_r)
      write_collision_flag_arm_r <= 1'h1;
  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_port_enable   = en_r;
  assign o_master_select = mst_r;
  assign o_flags         = '{transfer_done_flag:   done_r,
                             overrun_flag:         ovr_r,
                             mode_fault_flag:      mode_fault_flag_r,
                             write_collision_flag: write_collision_flag_r};
  assign o_rx_data       = rx_r;
  assign o_irq           = i_cfg.interrupt_enable && !i_cpu_interrupt_mask &&
                           (done_r || ovr_r || mode_fault_flag_r);
  assign o_sck           = sck_r;
  assign o_sck_oe        = master_en;
  assign o_mosi          = shift_r[7];
  assign o_mosi_oe       = master_en;
  assign o_miso          = shift_r[7];
  assign o_miso_oe       = slave_en;
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  done_sets_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    byte_end |=> done_r)
    else $error("done flag not set at byte end");
  ovr_sets_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    byte_end && done_r && !done_clr |=> ovr_r && $stable(rx_r))
    else $error("overrun not flagged or buffer changed");
  ovr_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_status_rd && !(byte_end && done_r) |=> !ovr_r)
    else $error("overrun not cleared by status access");
  fault_drops_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    master_en && !ss_int |=> mode_fault_flag_r && !en_r && !mst_r)
    else $error("mode fault did not drop enables");
  fault_blocks_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    mode_fault_flag_r && !mode_fault_flag_arm_r && !en_r && i_ctl_wr |=> !en_r)
    else $error("enable set during mode fault");
  write_collision_flag_discard_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    busy && i_data_wr && !wr_ignored && !capture
    |=> write_collision_flag_r && $stable(shift_r))
    else $error("colliding write altered shifter");
  write_collision_flag_no_irq_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_irq |-> (done_r || ovr_r || mode_fault_flag_r))
    else $error("interrupt without enabled event");
  ignore_wr_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    done_r && !done_arm_r && i_data_wr |=> !write_collision_flag_r ||
    $past(write_collision_flag_r))
    else $error("ignored write raised collision");
  idle_level_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    master_en && mstate_r == M_IDLE && $past(mstate_r) == M_IDLE
    && $stable(i_cfg.polarity) |-> sck_r == i_cfg.polarity)
    else $error("clock idle level wrong");
  master_len_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    master_en && wr_load && i_cfg.clock_rate_select == 3'h0
    |-> ##32 byte_end)
    else $error("master byte length wrong");
  pins_free_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !en_r |-> !o_sck_oe && !o_mosi_oe && !o_miso_oe)
    else $error("pins driven while disabled");
endmodule : spi_master_slave_port

// [verification/spi_far_model.sv]
// Far-side serial device: slave while the port masters, master otherwise
`timescale 1ns/1ns
module spi_far_model (
  // Pins seen from the far side
  input  wire logic i_sck,
  input  wire logic i_mosi,
  input  wire logic i_miso,
  // Timing mode shared with the port
  input  wire logic i_pol,
  input  wire logic i_pha,
  input  wire logic i_slave_role,
  // Pins driven by the far side
  output logic      o_sck,
  output logic      o_mosi,
  output logic      o_miso,
  output logic      o_ss_n
);
  logic [7:0] tx_r  = 8'h00;
  logic [7:0] rx_r  = 8'h00;
  logic       run_r = 1'b0;
  logic       sck_r = 1'b0;
  logic       mosi_dly;
  // Value just before an edge, since the port changes data on that edge
  assign #2 mosi_dly = i_mosi;
  // Clock stands at its idle level outside frames
  assign o_sck  = run_r ? sck_r : i_pol;
  // Released data line shows the inverse of the last bit
  assign o_miso = i_slave_role ? tx_r[7] : ~tx_r[7];
  initial
  begin
    o_ss_n = 1'b1;
    o_mosi = 1'b0;
  end
  // -------------------------------------------------------------------
  // Slave role
  // -------------------------------------------------------------------
  always @(i_sck)
  begin
    if (i_slave_role && (i_sck ^ i_pol ^ i_pha))
    begin
      rx_r = {rx_r[6:0], mosi_dly};
      // Next bit just after capture: the port reads its input late
      tx_r <= #10 {tx_r[6:0], 1'b0};
    end
  end
  // -------------------------------------------------------------------
  // Master role, 320 ns clock period
  // -------------------------------------------------------------------
  task automatic run_master(input logic [7:0] tx);
    o_ss_n = 1'b0;
    sck_r = i_pol;
    run_r = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      if (!i_pha) o_mosi = tx[i];
      #160 sck_r = ~i_pol;
      if (i_pha) o_mosi = tx[i];
      else rx_r = {rx_r[6:0], i_miso};
      #160 sck_r = i_pol;
      if (i_pha) rx_r = {rx_r[6:0], i_miso};
    end
    #160 run_r = 1'b0;
    o_ss_n = 1'b1;
    o_mosi = ~o_mosi;
  endtask : run_master
  task automatic select(input logic lvl);
    o_ss_n = lvl;
  endtask : select
endmodule : spi_far_model

// [verification/test_spi_master_slave_port.sv]
// Self-checking bench for the byte-wide serial port
`timescale 1ns/1ns
module test_spi_master_slave_port;
  import spi_port_pkg::*;
  localparam int ST = 0;
  localparam int RD = 1;
  localparam int WR = 2;
  localparam int CT = 3;
  logic       i_ref_clk, i_rst_n, i_cpu_interrupt_mask, i_ctl_wr;
  logic       i_ctl_port_enable, i_ctl_master_select, i_status_rd;
  logic       i_data_wr, i_data_rd, fault_ss_n;
  logic [7:0] i_data_wdata, o_rx_data;
  cfg_s       i_cfg;
  flags_s     o_flags;
  logic       o_port_enable, o_master_select, o_irq, o_sck, o_sck_oe;
  logic       o_mosi, o_mosi_oe, o_miso, o_miso_oe;
  logic       far_sck, far_mosi, far_miso, far_ss_n, sck_w, mosi_w, miso_w;
  int         failures, comparisons;
  assign sck_w  = o_sck_oe ? o_sck : far_sck;
  assign mosi_w = o_mosi_oe ? o_mosi : far_mosi;
  assign miso_w = o_miso_oe ? o_miso : far_miso;
  initial
  begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  spi_master_slave_port dut_u (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cfg(i_cfg),
    .i_cpu_interrupt_mask(i_cpu_interrupt_mask), .i_ctl_wr(i_ctl_wr),
    .i_ctl_port_enable(i_ctl_port_enable),
    .i_ctl_master_select(i_ctl_master_select), .i_status_rd(i_status_rd),
    .i_data_wr(i_data_wr), .i_data_wdata(i_data_wdata),
    .i_data_rd(i_data_rd), .o_port_enable(o_port_enable),
    .o_master_select(o_master_select), .o_flags(o_flags),
    .o_rx_data(o_rx_data), .o_irq(o_irq), .i_sck(sck_w), .o_sck(o_sck),
    .o_sck_oe(o_sck_oe), .i_mosi(mosi_w), .o_mosi(o_mosi),
    .o_mosi_oe(o_mosi_oe), .i_miso(miso_w), .o_miso(o_miso),
    .o_miso_oe(o_miso_oe), .i_ss_n(far_ss_n & fault_ss_n));
  spi_far_model far_u (
    .i_sck(sck_w), .i_mosi(mosi_w), .i_miso(miso_w),
    .i_pol(i_cfg.polarity), .i_pha(i_cfg.phase), .i_slave_role(o_sck_oe),
    .o_sck(far_sck), .o_mosi(far_mosi), .o_miso(far_miso),
    .o_ss_n(far_ss_n));
  // -------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------
  task automatic finish_test();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk_val(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask : chk_val
  // Flags, and the interrupt level they imply
  task automatic chk_flags(input logic [3:0] e);
    logic ei;
    ei = i_cfg.interrupt_enable & ~i_cpu_interrupt_mask & (|e[3:1]);
    comparisons += 2;
    if (o_flags !== e || o_irq !== ei)
    begin
      failures++;
      $display("unexpected flags: expected %h/%b seen %h/%b",
               e, ei, o_flags, o_irq);
    end
  endtask : chk_flags
  // Strobe, then one more cycle so the answer has landed
  task automatic pulse(input int k, input logic [7:0] b = 8'h00,
                       input logic en = 1'b0, input logic ms = 1'b0);
    @(negedge i_ref_clk);
    i_data_wdata = b;
    i_ctl_port_enable = en;
    i_ctl_master_select = ms;
    case (k)
      ST: i_status_rd = 1'b1;
      RD: i_data_rd = 1'b1;
      WR: i_data_wr = 1'b1;
      default: i_ctl_wr = 1'b1;
    endcase
    @(negedge i_ref_clk);
    {i_status_rd, i_data_rd, i_data_wr, i_ctl_wr} = 4'h0;
    @(negedge i_ref_clk);
  endtask : pulse
  task automatic wait_flag(input int idx, input int lim, output int n);
    n = 0;
    while (o_flags[idx] !== 1'b1)
    begin
      @(negedge i_ref_clk);
      n++;
      if (n > lim)
      begin
        failures++;
        $display("unexpected wait: expected flag %0d seen none", idx);
        finish_test();
      end
    end
  endtask : wait_flag
  task automatic set_mode(input logic [2:0] r, input logic pol,
                          input logic pha, input logic ms);
    pulse(CT);
    i_cfg.clock_rate_select = r;
    i_cfg.polarity = pol;
    i_cfg.phase = pha;
    pulse(CT, 8'h00, 1'b1, ms);
  endtask : set_mode
  // -------------------------------------------------------------------
  // Sequence
  // -------------------------------------------------------------------
  initial
  begin
    int n;
    logic [7:0] tx;
    logic [7:0] st;
    failures = 0;
    comparisons = 0;
    i_rst_n = 1'b0;
    i_cfg = 8'h01;
    {i_cpu_interrupt_mask, i_ctl_wr, i_ctl_port_enable} = 3'h0;
    {i_ctl_master_select, i_status_rd, i_data_wr, i_data_rd} = 4'h0;
    i_data_wdata = 8'h00;
    fault_ss_n = 1'b1;
    void'($urandom(67));
    repeat (8) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    chk_flags(4'h0);
    chk_val("pins", 0, {o_port_enable, o_master_select, o_sck_oe,
                        o_mosi_oe, o_miso_oe, o_rx_data});
    // Master: every rate code, four timing modes in turn
    for (int r = 0; r < 8; r++)
    begin
      i_cfg.interrupt_enable = 1'($urandom);
      i_cpu_interrupt_mask = 1'($urandom);
      set_mode(3'(r), r[0], r[1], 1'b1);
      chk_val("sck idle", r[0], sck_w);
      chk_val("oe", 7, {o_sck_oe, o_mosi_oe, ~o_miso_oe});
      tx = 8'($urandom);
      st = 8'($urandom);
      far_u.tx_r = st;
      pulse(WR, tx, 1'b1, 1'b1);
      wait_flag(3, 1100, n);
      // Counting starts two edges after the write is taken
      chk_val("cycles", 16'((r > 5 ? 1024 : 32 << r) - 1), 16'(n));
      chk_val("far rx", tx, far_u.rx_r);
      chk_val("rx", st, o_rx_data);
      chk_flags(4'h8);
      pulse(ST);
      pulse(RD);
      chk_flags(4'h0);
    end
    i_cfg.interrupt_enable = 1'b1;
    i_cpu_interrupt_mask = 1'b0;
    set_mode(3'h0, 1'b0, 1'b0, 1'b1);
    tx = 8'($urandom);
    pulse(WR, tx, 1'b1, 1'b1);
    pulse(WR, ~tx, 1'b1, 1'b1);
    chk_flags(4'h1);
    wait_flag(3, 40, n);
    chk_val("far rx", tx, far_u.rx_r);
    pulse(WR, 8'h5A);
    repeat (40) @(negedge i_ref_clk);
    chk_flags(4'h9);
    pulse(ST);
    pulse(RD);
    chk_flags(4'h0);
    // Second byte completes before done is cleared
    st = 8'($urandom);
    far_u.tx_r = st;
    pulse(WR, tx);
    wait_flag(3, 40, n);
    pulse(ST);
    far_u.tx_r = ~st;
    pulse(WR, ~tx);
    wait_flag(2, 40, n);
    chk_flags(4'hC);
    chk_val("rx", st, o_rx_data);
    pulse(ST);
    chk_flags(4'h8);
    pulse(RD);
    chk_flags(4'h0);
    // Mode fault from the pin, then from the software level
    for (int k = 0; k < 2; k++)
    begin
      i_cfg.select_by_software = k[0];
      fault_ss_n = ~k[0];
      set_mode(3'h0, 1'b0, 1'b0, 1'b1);
      repeat (6) @(negedge i_ref_clk);
      chk_val("enables", 3, {o_port_enable, o_master_select});
      fault_ss_n = k[0];
      i_cfg.software_select_level = 1'b0;
      wait_flag(1, 8, n);
      chk_flags(4'h2);
      chk_val("enables", 0, {o_port_enable, o_master_select});
      fault_ss_n = 1'b1;
      i_cfg.software_select_level = 1'b1;
      pulse(CT, 8'h00, 1'b1, 1'b1);
      chk_val("enables", 0, {o_port_enable, o_master_select});
      pulse(ST);
      pulse(CT, 8'h00, 1'b1, 1'b1);
      chk_flags(4'h0);
      chk_val("enables", 3, {o_port_enable, o_master_select});
    end
    i_cfg.select_by_software = 1'b0;
    // Slave: four timing modes against the far master
    for (int m = 0; m < 4; m++)
    begin
      set_mode(3'h0, m[0], m[1], 1'b0);
      tx = 8'($urandom);
      st = 8'($urandom);
      pulse(WR, tx, 1'b1);
      far_u.run_master(st);
      wait_flag(3, 20, n);
      chk_val("rx", st, o_rx_data);
      chk_val("far rx", tx, far_u.rx_r);
      pulse(ST);
      pulse(m[0] ? WR : RD);
      chk_flags(4'h0);
    end
    set_mode(3'h0, 1'b0, 1'b0, 1'b0);
    far_u.select(1'b0);
    repeat (4) @(negedge i_ref_clk);
    pulse(WR, 8'hA5);
    chk_flags(4'h1);
    far_u.select(1'b1);
    pulse(ST);
    pulse(WR, 8'h3C);
    chk_flags(4'h0);
    finish_test();
  end
endmodule : test_spi_master_slave_port
